// ---- logic/scpc_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "scpc_defines.svh"

// Notes on behaviour
// - configuration register resets to zero
// - power save divides internal clock
// - external interrupt clears power save bit
// - interrupt return never restores power save
// - software interrupts and exceptions leave it
// - single select mode widens first midrange select
// - strobe mode uses read timing always
// - enabling write: normal fall, strobe rise
// - disabling write: strobe fall, normal rise
// - demodulation enable bit drives demodulator
// - clock B picks full or divided
// - clock B driver disable tristates pin
// - clock A picks full or divided
// - clock A driver disable tristates pin
// - reserved bits seven to three read zero
// - divisor n divides by two power n
// - reset stops execution and bus cycles
// - after interval, boot state and first fetch
// - relocation register loads fixed value
// - upper memory select loads fixed value
// - refresh enable register loads zero
module scpc_top import scpc_pkg::*; #(
    parameter int RESET_CYC = `SCPC_RESET_INTERVAL_CYC
) (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [15:0] reg_rdata_o,
    input wire logic ext_irq_i,
    input wire logic bus_req_i,
    input wire logic bus_write_i,
    output logic bus_grant_o,
    output logic bus_idle_o,
    output logic data_enable_pin_n_o,
    input wire logic midrange_hit_i,
    input wire logic [3:0] midrange_select_n_i,
    output logic [3:0] midrange_select_n_o,
    output logic proc_clk_en_o,
    output logic clock_output_a_o,
    output logic clock_output_a_oe_o,
    output logic clock_output_b_o,
    output logic clock_output_b_oe_o,
    output logic pulse_demod_enable_o,
    output logic single_midrange_select_mode_o,
    output logic data_strobe_mode_enable_o,
    output logic core_run_o,
    output logic fetch_start_o,
    output logic [15:0] flags_init_o,
    output logic [15:0] code_seg_init_o,
    output logic [19:0] boot_addr_o,
    output logic [15:0] control_block_relocation_o,
    output logic [15:0] upper_memory_select_config_o,
    output logic [15:0] refresh_enable_register_o
);
    localparam int RCNT_W = $clog2(RESET_CYC + 1);

    scpc_cfg_if cfg_bus ();

    logic [15:0] system_configuration_r, system_configuration_nxt;
    logic [15:0] rdata_r, rdata_nxt;
    logic [15:0] reloc_r, upper_r, refresh_r;
    logic [15:0] flags_r, code_seg_r;
    logic [19:0] boot_r;
    logic [3:0] mid_r, mid_nxt;
    logic [1:0] clk_out_r, clk_out_nxt;
    logic [1:0] clk_full_sel;
    logic [1:0] clk_drive_dis;
    logic [1:0] clk_oe_r;
    scpc_rst_state_t rst_st_r, rst_st_nxt;
    logic [RCNT_W-1:0] rcnt_r, rcnt_nxt;
    logic fetch_r, fetch_nxt;
    logic strobe_idle;
    logic start_cycle;
    logic wr_syscfg;

    // address decode shared by read and write paths
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
        hit = (addr == ofs);
    endfunction

    assign wr_syscfg = reg_wr_i && hit(reg_addr_i, `SCPC_OFS_SYSCFG);

    // configuration register
    always_comb begin
        system_configuration_nxt = system_configuration_r;
        if (wr_syscfg) begin
            system_configuration_nxt = reg_wdata_i & `SCPC_SYSCFG_WMASK;
        end
        // an external interrupt clears it, as does a write of zero; the interrupt wins over a write
        if (ext_irq_i) begin
            system_configuration_nxt[`SCPC_BIT_POWER_SAVE_ENABLE] = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            system_configuration_r <= `SCPC_RST_SYSCFG;
        end else begin
            system_configuration_r <= system_configuration_nxt;
        end
    end

    // read port, data valid only in the cycle after the strobe
    always_comb begin
        rdata_nxt = 16'h0000;
        if (reg_rd_i) begin
            if (hit(reg_addr_i, `SCPC_OFS_SYSCFG)) begin
                rdata_nxt = system_configuration_r & `SCPC_SYSCFG_WMASK;
            end else if (hit(reg_addr_i, `SCPC_OFS_RELOC)) begin
                rdata_nxt = reloc_r;
            end else if (hit(reg_addr_i, `SCPC_OFS_UPPER)) begin
                rdata_nxt = upper_r;
            end else if (hit(reg_addr_i, `SCPC_OFS_REFRESH)) begin
                rdata_nxt = refresh_r;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_r <= 16'h0000;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata_o = rdata_r;

    // boot values held from reset onward
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            reloc_r <= `SCPC_RST_RELOC;
            upper_r <= `SCPC_RST_UPPER;
            refresh_r <= `SCPC_RST_REFRESH;
            flags_r <= `SCPC_RST_FLAGS;
            code_seg_r <= `SCPC_RST_CODE_SEG;
            boot_r <= `SCPC_RST_BOOT_ADDR;
        end else begin
            reloc_r <= reloc_r;
            upper_r <= upper_r;
            refresh_r <= refresh_r;
            flags_r <= flags_r;
            code_seg_r <= code_seg_r;
            boot_r <= boot_r;
        end
    end

    assign control_block_relocation_o = reloc_r;
    assign upper_memory_select_config_o = upper_r;
    assign refresh_enable_register_o = refresh_r;
    assign flags_init_o = flags_r;
    assign code_seg_init_o = code_seg_r;
    assign boot_addr_o = boot_r;

    // reset sequencer: wait the internal interval, then first fetch
    always_comb begin
        rst_st_nxt = rst_st_r;
        rcnt_nxt = rcnt_r;
        fetch_nxt = 1'b0;
        unique case (rst_st_r)
            RS_WAIT: begin
                if (rcnt_r == RCNT_W'(RESET_CYC - 1)) begin
                    rst_st_nxt = RS_FETCH;
                end else begin
                    rcnt_nxt = RCNT_W'(rcnt_r + 1'b1);
                end
            end
            RS_FETCH: begin
                rst_st_nxt = RS_RUN;
                fetch_nxt = 1'b1;
            end
            RS_RUN: begin
                rst_st_nxt = RS_RUN;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_st_r <= RS_WAIT;
            rcnt_r <= '0;
            fetch_r <= 1'b0;
        end else begin
            rst_st_r <= rst_st_nxt;
            rcnt_r <= rcnt_nxt;
            fetch_r <= fetch_nxt;
        end
    end

    assign core_run_o = (rst_st_r == RS_RUN);
    assign fetch_start_o = fetch_r;

    // clock divider and bus strobe timing
    assign cfg_bus.ps_en = system_configuration_r[`SCPC_BIT_POWER_SAVE_ENABLE];
    assign cfg_bus.divisor = system_configuration_r[`SCPC_DIV_LSB +: `SCPC_DIV_W];
    assign cfg_bus.ds_mode = system_configuration_r[`SCPC_BIT_DATA_STROBE_MODE_ENABLE];

    scpc_clk_div #(
        .CNT_W(7)
    ) u_div (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .cfg(cfg_bus.div)
    );

    assign proc_clk_en_o = cfg_bus.tick;

    // no bus cycle before the sequencer reaches run
    assign start_cycle = bus_req_i && core_run_o && strobe_idle;
    assign bus_grant_o = start_cycle;
    assign bus_idle_o = strobe_idle;

    scpc_strobe_gen u_strobe (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .cfg(cfg_bus.strobe),
        .start_i(start_cycle),
        .write_i(bus_write_i),
        .idle_o(strobe_idle),
        .data_enable_pin_n_o(data_enable_pin_n_o)
    );

    // midrange selects
    always_comb begin
        if (system_configuration_r[`SCPC_BIT_MCS]) begin
            mid_nxt = {3'h7, !midrange_hit_i};
        end else begin
            mid_nxt = midrange_select_n_i;
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mid_r <= 4'hF;
        end else begin
            mid_r <= mid_nxt;
        end
    end

    assign midrange_select_n_o = mid_r;

    // clock outputs: index 0 is A, index 1 is B
    assign clk_full_sel = {system_configuration_r[`SCPC_BIT_CBF],
                           system_configuration_r[`SCPC_BIT_CAF]};
    assign clk_drive_dis = {system_configuration_r[`SCPC_BIT_CBD],
                            system_configuration_r[`SCPC_BIT_CAD]};

    for (genvar i = 0; i < 2; i++) begin : g_clkout
        always_comb begin
            // full rate toggles every cycle, else on the divided enable
            if (clk_full_sel[i] || cfg_bus.tick) begin
                clk_out_nxt[i] = !clk_out_r[i];
            end else begin
                clk_out_nxt[i] = clk_out_r[i];
            end
        end

        always_ff @(posedge clk_sys_i or negedge resetn_i) begin
            if (!resetn_i) begin
                clk_out_r[i] <= 1'b0;
                clk_oe_r[i] <= 1'b1;
            end else begin
                clk_out_r[i] <= clk_out_nxt[i];
                clk_oe_r[i] <= !clk_drive_dis[i];
            end
        end
    end

    assign clock_output_a_o = clk_out_r[0];
    assign clock_output_b_o = clk_out_r[1];
    assign clock_output_a_oe_o = clk_oe_r[0];
    assign clock_output_b_oe_o = clk_oe_r[1];

    // mode levels for the rest of the chip
    assign pulse_demod_enable_o = system_configuration_r[`SCPC_BIT_PWD];
    assign single_midrange_select_mode_o = system_configuration_r[`SCPC_BIT_MCS];
    assign data_strobe_mode_enable_o = system_configuration_r[`SCPC_BIT_DATA_STROBE_MODE_ENABLE];
endmodule
`default_nettype wire

// ---- logic/scpc_defines.svh ----
`ifndef SCPC_DEFINES_SVH
`define SCPC_DEFINES_SVH

`define SCPC_CLK_PERIOD_NS 8
`define SCPC_RESET_INTERVAL_NS 64
`define SCPC_RESET_INTERVAL_CYC \
    ((`SCPC_RESET_INTERVAL_NS + `SCPC_CLK_PERIOD_NS - 1) / `SCPC_CLK_PERIOD_NS)

`define SCPC_OFS_SYSCFG 8'hF0
`define SCPC_OFS_RELOC 8'hFE
`define SCPC_OFS_UPPER 8'hA0
`define SCPC_OFS_REFRESH 8'hE4

`define SCPC_BIT_POWER_SAVE_ENABLE 15
`define SCPC_BIT_MCS 14
`define SCPC_BIT_DATA_STROBE_MODE_ENABLE 13
`define SCPC_BIT_PWD 12
`define SCPC_BIT_CBF 11
`define SCPC_BIT_CBD 10
`define SCPC_BIT_CAF 9
`define SCPC_BIT_CAD 8
`define SCPC_DIV_LSB 0
`define SCPC_DIV_W 3
`define SCPC_SYSCFG_WMASK 16'hFF07

`define SCPC_RST_SYSCFG 16'h0000
`define SCPC_RST_RELOC 16'h20FF
`define SCPC_RST_UPPER 16'hF03B
`define SCPC_RST_REFRESH 16'h0000
`define SCPC_RST_FLAGS 16'hF002
`define SCPC_RST_CODE_SEG 16'hFFFF
`define SCPC_RST_BOOT_ADDR 20'hFFFF0

`define SCPC_POS_T1_PH2 3'h1
`define SCPC_POS_T2_PH2 3'h3
`define SCPC_POS_T4_PH1 3'h6
`define SCPC_POS_T4_PH2 3'h7

`endif

// ---- logic/scpc_pkg.sv ----
`default_nettype none
package scpc_pkg;
    typedef enum logic [2:0] {
        RS_WAIT = 3'h1,
        RS_FETCH = 3'h2,
        RS_RUN = 3'h4
    } scpc_rst_state_t;

    typedef enum logic [4:0] {
        BS_IDLE = 5'h01,
        BS_T1 = 5'h02,
        BS_T2 = 5'h04,
        BS_T3 = 5'h08,
        BS_T4 = 5'h10
    } scpc_bus_state_t;
endpackage
`default_nettype wire

// ---- logic/scpc_cfg_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface scpc_cfg_if;
    logic ps_en;
    logic [2:0] divisor;
    logic tick;
    logic ds_mode;
    modport div (input ps_en, input divisor, output tick);
    modport strobe (input tick, input ds_mode);
    modport ctrl (output ps_en, output divisor, output ds_mode, input tick);
endinterface
`default_nettype wire

// ---- logic/scpc_clk_div.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "scpc_defines.svh"
module scpc_clk_div import scpc_pkg::*; #(
    parameter int CNT_W = 7
) (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    scpc_cfg_if.div cfg
);
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic [CNT_W-1:0] limit;

    // terminal count for divide by two to the power n
    function automatic logic [CNT_W-1:0] div_limit(input logic en, input logic [2:0] n);
        logic [CNT_W:0] one_hot;
        one_hot = '0;
        one_hot[n] = 1'b1;
        div_limit = en ? CNT_W'(one_hot - 1'b1) : '0;
    endfunction

    always_comb begin
        limit = div_limit(cfg.ps_en, cfg.divisor);
        cnt_nxt = (cnt_r >= limit) ? '0 : CNT_W'(cnt_r + 1'b1);
    end

    assign cfg.tick = (cnt_r >= limit);

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end
endmodule
`default_nettype wire

// ---- logic/scpc_strobe_gen.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "scpc_defines.svh"
module scpc_strobe_gen import scpc_pkg::*; (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    scpc_cfg_if.strobe cfg,
    input wire logic start_i,
    input wire logic write_i,
    output logic idle_o,
    output logic data_enable_pin_n_o
);
    scpc_bus_state_t st_r, st_nxt;
    logic ph2_r, ph2_nxt;
    logic wr_r, wr_nxt;
    logic mode_start_r, mode_start_nxt;
    logic den_n_r, den_n_nxt;
    logic [2:0] pos_nxt;
    logic [2:0] fall_pos;
    logic [2:0] rise_pos;

    always_comb begin
        st_nxt = st_r;
        ph2_nxt = ph2_r;
        wr_nxt = wr_r;
        mode_start_nxt = mode_start_r;
        unique case (st_r)
            BS_IDLE: begin
                if (start_i) begin
                    st_nxt = BS_T1;
                    ph2_nxt = 1'b0;
                    wr_nxt = write_i;
                    mode_start_nxt = cfg.ds_mode;
                end
            end
            default: begin
                if (cfg.tick) begin
                    ph2_nxt = ~ph2_r;
                    if (ph2_r) begin
                        unique case (st_r)
                            BS_T1: st_nxt = BS_T2;
                            BS_T2: st_nxt = BS_T3;
                            BS_T3: st_nxt = BS_T4;
                            default: st_nxt = BS_IDLE;
                        endcase
                    end
                end
            end
        endcase
        unique case (st_nxt)
            BS_T1: pos_nxt = {2'h0, ph2_nxt};
            BS_T2: pos_nxt = {2'h1, ph2_nxt};
            BS_T3: pos_nxt = {2'h2, ph2_nxt};
            default: pos_nxt = {2'h3, ph2_nxt};
        endcase
        // fall follows the mode held when the cycle began
        fall_pos = (wr_nxt && !mode_start_nxt) ? `SCPC_POS_T1_PH2 : `SCPC_POS_T2_PH2;
        // rise follows the mode in force at the end of the cycle
        rise_pos = (wr_nxt && !cfg.ds_mode) ? `SCPC_POS_T4_PH2 : `SCPC_POS_T4_PH1;
        den_n_nxt = !((st_nxt != BS_IDLE) && (pos_nxt >= fall_pos) && (pos_nxt < rise_pos));
    end

    assign idle_o = (st_r == BS_IDLE);
    assign data_enable_pin_n_o = den_n_r;

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_r <= BS_IDLE;
            ph2_r <= 1'b0;
            wr_r <= 1'b0;
            mode_start_r <= 1'b0;
            den_n_r <= 1'b1;
        end else begin
            st_r <= st_nxt;
            ph2_r <= ph2_nxt;
            wr_r <= wr_nxt;
            mode_start_r <= mode_start_nxt;
            den_n_r <= den_n_nxt;
        end
    end
endmodule
`default_nettype wire

// ---- bench/scpc_top_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module scpc_top_sva #(
    parameter int RESET_CYC = 8
) (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_rd_i,
    input wire logic [15:0] reg_rdata_o,
    input wire logic ext_irq_i,
    input wire logic bus_grant_o,
    input wire logic bus_idle_o,
    input wire logic data_enable_pin_n_o,
    input wire logic proc_clk_en_o,
    input wire logic core_run_o,
    input wire logic fetch_start_o,
    input wire logic midrange_hit_i,
    input wire logic single_midrange_select_mode_o,
    input wire logic [3:0] midrange_select_n_o
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!resetn_i);
    a_reserved_zero: assert property (
        reg_rd_i && reg_addr_i == 8'hF0 |=> reg_rdata_o[7:3] == 5'h00)
        else $error("reserved bits read nonzero");
    a_irq_full_speed: assert property (ext_irq_i |=> proc_clk_en_o[*2])
        else $error("clock still divided after interrupt");
    a_halt_no_grant: assert property (!core_run_o |-> !bus_grant_o)
        else $error("bus granted while halted");
    a_run_sticky: assert property (core_run_o |=> core_run_o)
        else $error("run dropped without reset");
    a_fetch_then_run: assert property (
        fetch_start_o |=> core_run_o && !fetch_start_o)
        else $error("fetch not followed by run");
    a_run_after_fetch: assert property ($rose(core_run_o) |-> fetch_start_o)
        else $error("run began without fetch");
    a_strobe_idle: assert property (bus_idle_o |-> data_enable_pin_n_o)
        else $error("strobe low while idle");
    a_strobe_first: assert property (bus_grant_o |=> data_enable_pin_n_o)
        else $error("strobe low in first phase");
    a_sel_widen: assert property (
        single_midrange_select_mode_o && midrange_hit_i |=> !midrange_select_n_o[0])
        else $error("first select not active");
endmodule
bind scpc_top scpc_top_sva #(.RESET_CYC(RESET_CYC)) i_scpc_top_sva (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .reg_addr_i(reg_addr_i),
    .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o),
    .ext_irq_i(ext_irq_i),
    .bus_grant_o(bus_grant_o),
    .bus_idle_o(bus_idle_o),
    .data_enable_pin_n_o(data_enable_pin_n_o),
    .proc_clk_en_o(proc_clk_en_o),
    .core_run_o(core_run_o),
    .fetch_start_o(fetch_start_o),
    .midrange_hit_i(midrange_hit_i),
    .single_midrange_select_mode_o(single_midrange_select_mode_o),
    .midrange_select_n_o(midrange_select_n_o)
);
`default_nettype wire

// ---- bench/tb_scpc_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_scpc_top;
    logic clk, rst_n, wr_s, rd_s, irq, req, bw, hit;
    logic [7:0] ad;
    logic [15:0] wd, rdat, flg, cs, rel, ups, rfr;
    logic [19:0] boot;
    logic [3:0] sel_i, sel_o;
    logic gnt, idle, data_enable_pin, pce, ca, ca_oe, cb, cb_oe, pulse_demod_enable, sm, dsm, run, fet;
    int err_total, total_checks;
    scpc_top #(.RESET_CYC(2)) i_scpc_top (
        .clk_sys_i(clk), .resetn_i(rst_n), .reg_addr_i(ad), .reg_wdata_i(wd),
        .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_rdata_o(rdat), .ext_irq_i(irq),
        .bus_req_i(req), .bus_write_i(bw), .bus_grant_o(gnt), .bus_idle_o(idle),
        .data_enable_pin_n_o(data_enable_pin), .midrange_hit_i(hit), .midrange_select_n_i(sel_i),
        .midrange_select_n_o(sel_o), .proc_clk_en_o(pce), .clock_output_a_o(ca),
        .clock_output_a_oe_o(ca_oe), .clock_output_b_o(cb), .clock_output_b_oe_o(cb_oe),
        .pulse_demod_enable_o(pulse_demod_enable), .single_midrange_select_mode_o(sm),
        .data_strobe_mode_enable_o(dsm), .core_run_o(run), .fetch_start_o(fet),
        .flags_init_o(flg), .code_seg_init_o(cs), .boot_addr_o(boot),
        .control_block_relocation_o(rel), .upper_memory_select_config_o(ups),
        .refresh_enable_register_o(rfr)
    );
    always #4 clk = ~clk;
    task automatic end_of_test;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        ad <= a;
        wd <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk);
        ad <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        @(negedge clk);
        d = rdat;
    endtask
    // counts enable pulses and toggles of both clock pins
    task automatic cnt(input int n, output int pc, output int ta, output int tb);
        logic pa, pb;
        pc = 0;
        ta = 0;
        tb = 0;
        @(negedge clk);
        pa = ca;
        pb = cb;
        repeat (n) begin
            @(negedge clk);
            pc += int'(pce === 1'b1);
            ta += int'(ca !== pa);
            tb += int'(cb !== pb);
            pa = ca;
            pb = cb;
        end
    endtask
    task automatic t_reset;
        logic [15:0] d;
        int i;
        i = 0;
        do begin
            @(negedge clk);
            i++;
        end while (fet !== 1'b1 && i < 20);
        chk("fetch", fet, 1'b1);
        chk("run", run, 1'b1);
        chk("flags", flg, 16'hF002);
        chk("code_seg", cs, 16'hFFFF);
        chk("boot", boot, 20'hFFFF0);
        chk("reloc_o", rel, 16'h20FF);
        chk("upper_o", ups, 16'hF03B);
        chk("refresh_o", rfr, 16'h0000);
        rd(8'hF0, d);
        chk("syscfg", d, 16'h0000);
        wr(8'hFE, 16'h0000);
        rd(8'hFE, d);
        chk("reloc", d, 16'h20FF);
        rd(8'hA0, d);
        chk("upper", d, 16'hF03B);
        rd(8'hE4, d);
        chk("refresh", d, 16'h0000);
        rd(8'h10, d);
        chk("unmapped", d, 16'h0000);
    endtask
    task automatic t_regs;
        logic [15:0] d;
        wr(8'hF0, 16'hFFFF);
        rd(8'hF0, d);
        chk("syscfg", d, 16'hFF07);
        chk("modes", {pulse_demod_enable, sm, dsm}, 3'h7);
        chk("oe_off", {ca_oe, cb_oe}, 2'h0);
        wr(8'hF0, 16'h0000);
        repeat (2) @(negedge clk);
        chk("oe_on", {pulse_demod_enable, ca_oe, cb_oe}, 3'h3);
    endtask
    task automatic t_div;
        int pc, ta, tb;
        for (int n = 0; n < 8; n++) begin
            wr(8'hF0, 16'h8000 | 16'(n));
            cnt(256, pc, ta, tb);
            chk("div", pc, 256 >> n);
            chk("clk_a", ta, 256 >> n);
        end
        wr(8'hF0, 16'h0007);
        cnt(16, pc, ta, tb);
        chk("undiv", pc, 16);
        wr(8'hF0, 16'h8A02);
        cnt(8, pc, ta, tb);
        chk("full_a", ta, 8);
        chk("full_b", tb, 8);
        wr(8'hF0, 16'h8002);
        cnt(32, pc, ta, tb);
        chk("divclk", pc, 8);
        chk("divclk_a", ta, 8);
        chk("divclk_b", tb, 8);
    endtask
    task automatic t_irq;
        logic [15:0] d;
        int pc, ta, tb;
        wr(8'hF0, 16'h8003);
        @(posedge clk);
        irq <= 1'b1;
        @(posedge clk);
        irq <= 1'b0;
        rd(8'hF0, d);
        chk("irq_clr", d, 16'h0003);
        cnt(8, pc, ta, tb);
        chk("irq_speed", pc, 8);
        fork
            wr(8'hF0, 16'h8003);
            begin
                @(posedge clk);
                irq <= 1'b1;
                @(posedge clk);
                irq <= 1'b0;
            end
        join
        rd(8'hF0, d);
        chk("irq_win", d, 16'h0003);
    endtask
    task automatic t_sel;
        @(posedge clk);
        hit <= 1'b1;
        wr(8'hF0, 16'h0000);
        @(negedge clk);
        chk("sel_norm", sel_o, 4'h5);
        wr(8'hF0, 16'h4000);
        repeat (2) @(negedge clk);
        chk("sel_wide", sel_o[0], 1'b0);
        chk("sel_rest", sel_o, 4'hE);
        @(posedge clk);
        hit <= 1'b0;
    endtask
    task automatic bus_run(input logic w, m0, m1, input int f, input int r);
        logic [8:0] seen, exp;
        int i;
        wr(8'hF0, {2'b00, m0, 13'h0000});
        @(posedge clk);
        req <= 1'b1;
        bw <= w;
        i = 0;
        do begin
            @(negedge clk);
            i++;
        end while (gnt !== 1'b1 && i < 20);
        chk("grant", gnt, 1'b1);
        chk("idle", idle, 1'b1);
        @(posedge clk);
        req <= 1'b0;
        fork
            if (m1 !== m0) wr(8'hF0, {2'b00, m1, 13'h0000});
            for (int k = 0; k < 9; k++) begin
                @(negedge clk);
                seen[k] = data_enable_pin;
            end
        join
        for (i = 0; i < 9; i++) exp[i] = !(i >= f && i < r);
        chk("strobe", seen, exp);
    endtask
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        {wr_s, rd_s, irq, bw, hit} = 5'h00;
        req = 1'b1;
        ad = 8'h00;
        wd = 16'h0000;
        sel_i = 4'h5;
        err_total = 0;
        total_checks = 0;
        repeat (4) @(posedge clk);
        @(negedge clk);
        chk("halt", {run, gnt}, 2'h0);
        @(posedge clk);
        rst_n <= 1'b1;
        req <= 1'b0;
        t_reset();
        t_regs();
        t_div();
        t_irq();
        t_sel();
        bus_run(1'b0, 1'b0, 1'b0, 3, 6);
        bus_run(1'b0, 1'b1, 1'b1, 3, 6);
        bus_run(1'b1, 1'b0, 1'b0, 1, 7);
        bus_run(1'b1, 1'b1, 1'b1, 3, 6);
        bus_run(1'b1, 1'b0, 1'b1, 1, 6);
        bus_run(1'b1, 1'b1, 1'b0, 3, 7);
        end_of_test();
    end
    initial begin
        #400000;
        err_total++;
        end_of_test();
    end
endmodule
`default_nettype wire
